// ===== logic/mic_consts.vh
/*
 * constants for the interrupt controller: register indices, field
 * positions, reset values and vector addresses.
 * assumes it is included by bare name from the design, checker and bench files.
 */
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// ****************************************************************
// register indices (printed offsets 0x8, 0x9 are not word
// aligned, so they are indices and the byte address is index * 4)
// ****************************************************************
`define MIC_IDX_CONTROL 8'h08
`define MIC_IDX_STATUS 8'h09
`define MIC_IDX_MODE 8'h0a
`define MIC_IDX_KEYEN 8'h0b
`define MIC_IDX_SRC 8'h0c
`define MIC_IDX_VEC 8'h0d

// ****************************************************************
// control fields
// ****************************************************************
`define MIC_CTL_A_EN 7
`define MIC_CTL_B_EN 6
`define MIC_CTL_KW_EN 4
`define MIC_CTL_A_EDGE 3
`define MIC_CTL_B_EDGE 2
`define MIC_CTL_RESET 8'h00

// ****************************************************************
// status fields
// ****************************************************************
`define MIC_ST_A_FLAG 7
`define MIC_ST_B_FLAG 6
`define MIC_ST_KW_FLAG 4
`define MIC_ST_A_CLR 3
`define MIC_ST_B_CLR 2
`define MIC_ST_KW_CLR 0

// ****************************************************************
// vectors (low byte address of each pair)
// ****************************************************************
`define MIC_VEC_TBASE 16'hfff0
`define MIC_VEC_SERIAL 16'hfff2
`define MIC_VEC_TMR_B 16'hfff4
`define MIC_VEC_TMR_A 16'hfff6
`define MIC_VEC_KWAKE 16'hfff8
`define MIC_VEC_EXT 16'hfffa
`define MIC_VEC_TRAP 16'hfffc
`define MIC_VEC_RESET 16'hfffe
`define MIC_BOOT_OFFSET 16'h0010

// ****************************************************************
// source codes
// ****************************************************************
`define MIC_SRC_NONE 3'h0
`define MIC_SRC_RESET 3'h1
`define MIC_SRC_EXT 3'h2
`define MIC_SRC_KWAKE 3'h3
`define MIC_SRC_TMR_A 3'h4
`define MIC_SRC_TMR_B 3'h5
`define MIC_SRC_SERIAL 3'h6
`define MIC_SRC_TBASE 3'h7

`endif

// ===== logic/mic_intc.v
/*
 * reset and interrupt controller for an 8-bit core: vector choice,
 * fixed priority, enables, global mask, two external request pins,
 * eight key wake-up inputs, and an axi4-lite register slave.
 * assumes all pins are synchronous to aclk and the cpu core pulses
 * its sequencing strobes for one cycle each.
 */
// Design decision made here: the AXI4-Lite slave port.
// Contract
// - user modes place all vectors in FFF0 through FFFF
// - bootstrap mode takes vectors from FFE0 through FFEF
// - fixed priority: reset, external, key, timer a, timer b, serial, base
// - any reset sets the global mask bit
// - mask bit set by hardware after condition byte is stacked
// - maskable sources gated by local enable and global mask
// - software trap never pre-empts a running interrupt sequence
// - after trap fetch only reset honoured until first handler instruction
// - software trap uses vector FFFC and sets the mask bit
// - both external requests share FFFA, each with own enable
// - select 0 means low level and falling edge, 1 edge only
// - external interrupt only when enable and flag both set
// - pin-level branch tests only external request a
// - eight key wake-up inputs, each with its own enable bit
// - enabled falling edge latches input and sets shared key flag
// - clearing key flag clears all eight input latches
// - key request reaches cpu one cycle after flag or enable
// - control bits 7,6,4,3,2; bits 5,1,0 read zero; reset 0
// - status bits 7,6,4 are read-only flags, writes ignored
// - status bits 3,2,0 are clear strobes, always read zero
// - writing one clears flag, zero does nothing, reset clears all
// - flag set by edge or low level per select bit
`include "mic_consts.vh"

module mic_intc (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire ext_request_a_n,
   input wire ext_request_b_n,
   input wire [7:0] key_wakeup_n,
   input wire bootstrap_mode,
   input wire pin_reset,
   input wire watchdog_reset,
   input wire timer_a_irq,
   input wire timer_b_irq,
   input wire serial_irq,
   input wire time_base_irq,
   input wire software_trap_fetch,
   input wire stack_cc_done,
   input wire handler_first_done,
   input wire mask_clear,
   input wire mask_set,
   output reg irq_to_cpu,
   output reg [2:0] irq_source,
   output reg [15:0] vector_addr,
   output reg global_mask,
   output reg branch_pin_level
);

   reg [7:0] ctl_q;
   reg a_flag_q;
   reg b_flag_q;
   reg kw_flag_q;
   reg [7:0] key_latch_q;
   reg [7:0] key_en_q;
   reg a_prev_q;
   reg b_prev_q;
   reg [7:0] key_prev_q;
   reg kw_req_q;
   reg seq_q;
   reg trap_q;
   reg aw_q;
   reg w_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   // indices widened to the constants' width so no bits are dropped
   wire [7:0] wr_idx = {2'b00, awaddr_q[7:2]};
   wire [7:0] rd_idx = {2'b00, s_axi_araddr[7:2]};
   // address and data may arrive in either order; both wait here
   wire wr_go = aw_q && w_q && !s_axi_bvalid;
   wire wr_en = wr_go && wstrb_q[0];
   wire wr_ctl = wr_en && wr_idx == `MIC_IDX_CONTROL;
   wire wr_st = wr_en && wr_idx == `MIC_IDX_STATUS;
   wire wr_key = wr_en && wr_idx == `MIC_IDX_KEYEN;
   wire wr_hit = wr_idx == `MIC_IDX_CONTROL ||
      wr_idx == `MIC_IDX_STATUS ||
      wr_idx == `MIC_IDX_MODE ||
      wr_idx == `MIC_IDX_KEYEN ||
      wr_idx == `MIC_IDX_SRC ||
      wr_idx == `MIC_IDX_VEC;

   assign s_axi_awready = !aw_q;
   assign s_axi_wready = !w_q;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire [7:0] ctl_rd = {ctl_q[7:6], 1'b0, ctl_q[4:2], 2'b00};
   wire [7:0] st_rd = {a_flag_q, b_flag_q, 1'b0, kw_flag_q, 4'h0};

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (rd_idx)
            `MIC_IDX_CONTROL: s_axi_rdata <= {24'h000000, ctl_rd};
            `MIC_IDX_STATUS: s_axi_rdata <= {24'h000000, st_rd};
            `MIC_IDX_MODE: s_axi_rdata <= {31'h0, bootstrap_mode};
            `MIC_IDX_KEYEN: s_axi_rdata <= {24'h000000, key_en_q};
            `MIC_IDX_SRC: s_axi_rdata <= {24'h000000, key_latch_q};
            `MIC_IDX_VEC: s_axi_rdata <= {16'h0000, vector_addr};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // control and key-enable registers
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= `MIC_CTL_RESET;
         key_en_q <= 8'h00;
      end else begin
         if (wr_ctl)
            ctl_q <= wdata_q[7:0] & 8'hdc;
         if (wr_key)
            key_en_q <= wdata_q[7:0];
      end
   end

   // ****************************************************************
   // external request pins
   // ****************************************************************
   // pin high at reset avoids a false edge on the first cycle
   wire a_fall = a_prev_q && !ext_request_a_n;
   wire b_fall = b_prev_q && !ext_request_b_n;
   wire a_set = ctl_q[`MIC_CTL_A_EDGE] ? a_fall : !ext_request_a_n;
   wire b_set = ctl_q[`MIC_CTL_B_EDGE] ? b_fall : !ext_request_b_n;
   wire a_clr = wr_st && wdata_q[`MIC_ST_A_CLR];
   wire b_clr = wr_st && wdata_q[`MIC_ST_B_CLR];
   wire kw_clr = wr_st && wdata_q[`MIC_ST_KW_CLR];

   always @(posedge aclk) begin
      if (!aresetn) begin
         a_prev_q <= 1'b1;
         b_prev_q <= 1'b1;
         a_flag_q <= 1'b0;
         b_flag_q <= 1'b0;
         branch_pin_level <= 1'b1;
      end else begin
         a_prev_q <= ext_request_a_n;
         b_prev_q <= ext_request_b_n;
         // set wins over a simultaneous clear
         a_flag_q <= a_set | (a_flag_q & !a_clr);
         b_flag_q <= b_set | (b_flag_q & !b_clr);
         branch_pin_level <= ext_request_a_n;
      end
   end

   // ****************************************************************
   // key wake-up latches, one per input
   // ****************************************************************
   wire [7:0] key_fall;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_key
         assign key_fall[gi] = key_prev_q[gi] && !key_wakeup_n[gi] &&
            key_en_q[gi];
      end
   endgenerate

   always @(posedge aclk) begin
      if (!aresetn) begin
         key_prev_q <= 8'hff;
         key_latch_q <= 8'h00;
      end else begin
         key_prev_q <= key_wakeup_n;
         // one clear empties every latch; a new edge still wins
         key_latch_q <= key_fall | (key_latch_q & {8{!kw_clr}});
      end
   end

   wire kw_set = |key_fall;

   always @(posedge aclk) begin
      if (!aresetn) begin
         kw_flag_q <= 1'b0;
         kw_req_q <= 1'b0;
      end else begin
         kw_flag_q <= kw_set | (kw_flag_q & !kw_clr);
         // one cycle between flag/enable and the cpu request
         kw_req_q <= kw_flag_q & ctl_q[`MIC_CTL_KW_EN];
      end
   end

   // ****************************************************************
   // global mask and sequencing
   // ****************************************************************
   // reset sources override every cpu strobe in the same cycle
   wire any_reset = pin_reset | watchdog_reset;

   always @(posedge aclk) begin
      if (!aresetn) begin
         global_mask <= 1'b1;
         seq_q <= 1'b0;
         trap_q <= 1'b0;
      end else if (any_reset) begin
         global_mask <= 1'b1;
         seq_q <= 1'b0;
         trap_q <= 1'b0;
      end else begin
         if (stack_cc_done)
            global_mask <= 1'b1;
         else if (mask_set)
            global_mask <= 1'b1;
         else if (mask_clear)
            global_mask <= 1'b0;
         // a running sequence blocks the trap from taking over
         if (software_trap_fetch && !seq_q)
            trap_q <= 1'b1;
         else if (handler_first_done)
            trap_q <= 1'b0;
         if (irq_to_cpu && !trap_q)
            seq_q <= 1'b1;
         else if (handler_first_done)
            seq_q <= 1'b0;
      end
   end

   // ****************************************************************
   // priority resolution and vector
   // ****************************************************************
   wire a_req = ctl_q[`MIC_CTL_A_EN] & a_flag_q;
   wire b_req = ctl_q[`MIC_CTL_B_EN] & b_flag_q;
   wire ext_req = a_req | b_req;
   wire open_gate = !global_mask && !trap_q;
   reg [2:0] src_d;
   reg [15:0] vec_d;

   // reset ignores both the mask and the trap window
   always @* begin
      src_d = `MIC_SRC_NONE;
      if (any_reset)
         src_d = `MIC_SRC_RESET;
      else if (open_gate && ext_req)
         src_d = `MIC_SRC_EXT;
      else if (open_gate && kw_req_q)
         src_d = `MIC_SRC_KWAKE;
      else if (open_gate && timer_a_irq)
         src_d = `MIC_SRC_TMR_A;
      else if (open_gate && timer_b_irq)
         src_d = `MIC_SRC_TMR_B;
      else if (open_gate && serial_irq)
         src_d = `MIC_SRC_SERIAL;
      else if (open_gate && time_base_irq)
         src_d = `MIC_SRC_TBASE;
      case (src_d)
         `MIC_SRC_RESET: vec_d = `MIC_VEC_RESET;
         `MIC_SRC_EXT: vec_d = `MIC_VEC_EXT;
         `MIC_SRC_KWAKE: vec_d = `MIC_VEC_KWAKE;
         `MIC_SRC_TMR_A: vec_d = `MIC_VEC_TMR_A;
         `MIC_SRC_TMR_B: vec_d = `MIC_VEC_TMR_B;
         `MIC_SRC_SERIAL: vec_d = `MIC_VEC_SERIAL;
         `MIC_SRC_TBASE: vec_d = `MIC_VEC_TBASE;
         default: vec_d = `MIC_VEC_TRAP;
      endcase
      if (bootstrap_mode)
         vec_d = vec_d - `MIC_BOOT_OFFSET;
   end

   // source and vector registered together so the cpu sees one pair
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_to_cpu <= 1'b0;
         irq_source <= `MIC_SRC_NONE;
         vector_addr <= `MIC_VEC_RESET;
      end else begin
         irq_to_cpu <= src_d != `MIC_SRC_NONE;
         irq_source <= src_d;
         vector_addr <= vec_d;
      end
   end

endmodule // mic_intc

// ===== verification/mic_intc_properties.sv
/* assertion checker for mic_intc, bound into every instance.
   assumes the cpu pulses its sequencing strobes one cycle each. */
`include "mic_consts.vh"
module mic_intc_properties (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire ext_request_a_n,
   input wire bootstrap_mode,
   input wire pin_reset,
   input wire watchdog_reset,
   input wire software_trap_fetch,
   input wire stack_cc_done,
   input wire handler_first_done,
   input wire mask_clear,
   input wire irq_to_cpu,
   input wire [2:0] irq_source,
   input wire [15:0] vector_addr,
   input wire global_mask,
   input wire branch_pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   reg trap_q;
   wire [15:0] exp_w = (irq_source == `MIC_SRC_RESET ? `MIC_VEC_RESET :
      `MIC_VEC_TBASE + {12'h0, 3'h7 - irq_source, 1'b0}) -
      (bootstrap_mode ? `MIC_BOOT_OFFSET : 16'h0000);
   // a reset source ends the trap window as well
   always @(posedge aclk)
      if (!aresetn || pin_reset || watchdog_reset || handler_first_done)
         trap_q <= 1'b0;
      else if (software_trap_fetch)
         trap_q <= 1'b1;
   // **********
   // properties
   // **********
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence any_reset_s;
      pin_reset || watchdog_reset;
   endsequence
   reset_mask_a: assert property (
      $rose(aresetn) |-> global_mask) else $error("mask clear after reset");
   src_reset_a: assert property (
      any_reset_s |=> global_mask && irq_source == `MIC_SRC_RESET)
      else $error("reset source not served");
   vector_map_a: assert property (
      irq_source != `MIC_SRC_NONE && $stable(bootstrap_mode) |->
      vector_addr == exp_w) else $error("wrong vector");
   class_mask_a: assert property (
      irq_to_cpu && irq_source > `MIC_SRC_RESET |->
      !$past(global_mask)) else $error("mask ignored");
   stack_mask_a: assert property (
      stack_cc_done |=> global_mask) else $error("mask not set on stack");
   trap_hold_a: assert property (
      trap_q && irq_to_cpu |-> irq_source == `MIC_SRC_RESET)
      else $error("source honoured in trap");
   branch_copy_a: assert property (
      branch_pin_level == $past(ext_request_a_n))
      else $error("branch level not pin a");
   read_answer_a: assert property (
      rd_take_s |=> s_axi_rvalid) else $error("read not answered");
   wr_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule // mic_intc_properties

bind mic_intc mic_intc_properties chk_u (.*);

// ===== verification/mic_cpu_model.sv
/* cpu partner: takes a request or trap, stacks, runs first handler op.
   assumes slow and trap_req come from the bench. */
module mic_cpu_model (
   input wire aclk,
   input wire aresetn,
   input wire irq_to_cpu,
   input wire slow,
   input wire trap_req,
   output reg software_trap_fetch,
   output reg stack_cc_done,
   output reg handler_first_done
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [1:0] st_q;
   reg [3:0] wait_q;
   wire [3:0] gap_w = slow ? 4'h6 : 4'h1;
   always @(posedge aclk) begin
      software_trap_fetch <= 1'b0;
      stack_cc_done <= 1'b0;
      handler_first_done <= 1'b0;
      if (!aresetn) begin
         st_q <= 2'h0;
         wait_q <= 4'h0;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else begin
         case (st_q)
            // trap fetched only between sequences, never inside one
            2'h0: if (trap_req || irq_to_cpu) begin
               software_trap_fetch <= trap_req;
               st_q <= 2'h1;
               wait_q <= gap_w;
            end
            2'h1: begin
               stack_cc_done <= 1'b1;
               st_q <= 2'h2;
               wait_q <= gap_w;
            end
            default: begin
               handler_first_done <= 1'b1;
               st_q <= 2'h0;
               wait_q <= 4'h2;
            end
         endcase
      end
   end
endmodule // mic_cpu_model

// ===== verification/tb.sv
/* self-checking bench for mic_intc over axi4-lite.
   assumes mic_cpu_model answers requests and traps. */
`include "mic_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
      miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
   localparam [7:0] CTL = `MIC_IDX_CONTROL << 2;
   localparam [7:0] ST = `MIC_IDX_STATUS << 2;
   localparam [7:0] KEN = `MIC_IDX_KEYEN << 2;
   localparam [7:0] LAT = `MIC_IDX_SRC << 2;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, ext_request_a_n = 1'b1, ext_request_b_n = 1'b1;
   logic bootstrap_mode = 1'b0, pin_reset = 1'b0, watchdog_reset = 1'b0;
   logic mask_clear = 1'b0, mask_set = 1'b0, slow = 1'b0, trap_req = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd;
   logic [7:0] key_wakeup_n = 8'hff;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0, per_irq = 4'h0;
   logic [1:0] rs, bs;
   wire timer_a_irq, timer_b_irq, serial_irq, time_base_irq;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire irq_to_cpu, global_mask, branch_pin_level;
   wire [2:0] irq_source;
   wire [15:0] vector_addr;
   wire software_trap_fetch, stack_cc_done, handler_first_done;
   int miscompares = 0, tests_run = 0, cyc = 0;
   assign {timer_a_irq, timer_b_irq, serial_irq, time_base_irq} = per_irq;
   mic_intc dut_u (.*);
   mic_cpu_model cpu_u (.*);
   initial forever #5 aclk = ~aclk;
   // a hang counts as a mismatch and still ends in the report
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         stop_test();
      end
   end
   // **********
   // bus and helper tasks
   // **********
   task automatic wr(input [7:0] a, input [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      bs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input [7:0] a, input [7:0] e);
      rdr(a);
      `CHK("register", e, rd)
   endtask
   task automatic mclr();
      mask_clear <= 1'b1;
      @(posedge aclk);
      mask_clear <= 1'b0;
   endtask
   task automatic wirq(input [2:0] s);
      int n;
      logic [15:0] ev;
      n = 0;
      ev = `MIC_VEC_TBASE + {12'h0, 3'h7 - s, 1'b0};
      if (bootstrap_mode) ev = ev - `MIC_BOOT_OFFSET;
      do begin
         @(posedge aclk);
         n++;
      end while (irq_to_cpu !== 1'b1 && n < 20);
      `CHK("irq", 1'b1, irq_to_cpu)
      `CHK("source", s, irq_source)
      `CHK("vector", ev, vector_addr)
      repeat (10) @(posedge aclk);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("mask", 1'b1, global_mask)
      `CHK("vector", 16'hfffe, vector_addr)
      rchk(CTL, 8'h00);
      rchk(ST, 8'h00);
      rchk(8'h28, 8'h00);
      wr(CTL, 8'hff);
      `CHK("bresp", 2'h0, bs)
      rchk(CTL, 8'hdc);
      wr(ST, 8'hff);
      rchk(ST, 8'h00);
      wr(CTL, 8'h00);
      rdr(8'h38);
      `CHK("resp", 2'h2, rs)
      wr(8'h38, 8'hff);
      `CHK("bresp", 2'h2, bs)
      ext_request_a_n <= 1'b0;
      rchk(ST, 8'h80);
      `CHK("branch", 1'b0, branch_pin_level)
      wr(ST, 8'h08);
      rchk(ST, 8'h80);
      ext_request_a_n <= 1'b1;
      wr(ST, 8'hf4);
      rchk(ST, 8'h80);
      mclr();
      repeat (3) @(posedge aclk);
      `CHK("irq", 1'b0, irq_to_cpu)
      mask_set <= 1'b1;
      @(posedge aclk);
      mask_set <= 1'b0;
      wr(CTL, 8'h80);
      repeat (3) @(posedge aclk);
      `CHK("mask", 1'b1, global_mask)
      `CHK("irq", 1'b0, irq_to_cpu)
      mclr();
      wirq(3'h2);
      wr(ST, 8'h08);
      wr(CTL, 8'h04);
      ext_request_b_n <= 1'b0;
      rchk(ST, 8'h40);
      `CHK("branch", 1'b1, branch_pin_level)
      wr(ST, 8'h04);
      rchk(ST, 8'h00);
      wr(KEN, 8'h01);
      rchk(KEN, 8'h01);
      key_wakeup_n <= 8'hfd;
      rchk(ST, 8'h00);
      key_wakeup_n <= 8'hfc;
      rchk(ST, 8'h10);
      rchk(LAT, 8'h01);
      ext_request_b_n <= 1'b1;
      @(posedge aclk);
      ext_request_b_n <= 1'b0;
      wr(CTL, 8'h54);
      @(posedge aclk);
      mclr();
      wirq(3'h2);
      wr(ST, 8'h04);
      mclr();
      wirq(3'h3);
      wr(ST, 8'h01);
      rchk(LAT, 8'h00);
      rchk(ST, 8'h00);
      for (int i = 4; i < 8; i++) begin
         per_irq <= 4'h8 >> (i - 4);
         bootstrap_mode <= i[0];
         repeat (4) @(posedge aclk);
         `CHK("irq", 1'b0, irq_to_cpu)
         rchk(8'h28, {7'h00, i[0]});
         mclr();
         wirq(i[2:0]);
         per_irq <= 4'h0;
         @(posedge aclk);
      end
      bootstrap_mode <= 1'b0;
      slow <= 1'b1;
      trap_req <= 1'b1;
      @(posedge aclk);
      trap_req <= 1'b0;
      per_irq <= 4'h8;
      mclr();
      repeat (3) @(posedge aclk);
      `CHK("irq", 1'b0, irq_to_cpu)
      for (int k = 0; k < 2; k++) begin
         {pin_reset, watchdog_reset} <= 2'h2 >> k;
         @(posedge aclk);
         {pin_reset, watchdog_reset} <= 2'h0;
         @(posedge aclk);
         `CHK("mask", 1'b1, global_mask)
         `CHK("source", `MIC_SRC_RESET, irq_source)
      end
      per_irq <= 4'h0;
      repeat (20) @(posedge aclk);
      stop_test();
   end
endmodule // tb
